// ===== core/iwdt_pkg.sv
// Shared constants, field layouts and types of the instruction word decoder.
// Assumes a 24-bit program word with the opcode in the top byte.
package iwdt_pkg;

	// Widths
	localparam int WORD_W  = 24;
	localparam int OPC_W   = 8;
	localparam int OPND_W  = 16;
	localparam int REG_W   = 4;
	localparam int MODE_W  = 3;
	localparam int LIT_W   = 10;
	localparam int FILE_W  = 13;
	localparam int CYC_W   = 2;

	// Opcodes with a fixed meaning
	localparam logic [OPC_W-1:0] OPC_NOP        = 8'h00;
	localparam logic [OPC_W-1:0] OPC_COMPUTED   = 8'h01;
	localparam logic [OPC_W-1:0] OPC_CALL_ABS   = 8'h02;
	localparam logic [OPC_W-1:0] OPC_JUMP_ABS   = 8'h04;
	localparam logic [OPC_W-1:0] OPC_INT_EXIT   = 8'h05;
	localparam logic [OPC_W-1:0] OPC_RETURN     = 8'h06;
	localparam logic [OPC_W-1:0] OPC_MOVE_DWORD = 8'h08;
	localparam logic [OPC_W-1:0] OPC_JUMP_REL   = 8'h37;
	localparam logic [OPC_W-1:0] OPC_SKIP_CLR   = 8'hA6;
	localparam logic [OPC_W-1:0] OPC_SKIP_SET   = 8'hA7;
	localparam logic [OPC_W-1:0] OPC_TBL_RD     = 8'hBA;
	localparam logic [OPC_W-1:0] OPC_TBL_WR     = 8'hBB;

	// Opcode groups by upper nibble
	localparam logic [3:0] GRP_COND  = 4'h3;
	localparam logic [3:0] GRP_W3_LO = 4'h4;
	localparam logic [3:0] GRP_W3_HI = 4'h6;
	localparam logic [3:0] GRP_LIT   = 4'h7;
	localparam logic [3:0] GRP_BIT   = 4'hA;
	localparam logic [3:0] GRP_FILE  = 4'hE;

	// Operand field positions
	localparam int SRC_LSB        = 0;
	localparam int DST_LSB        = 7;
	localparam int W3_BYTE_POS    = 14;
	localparam int FILE_BYTE_POS  = 14;
	localparam int FILE_W0_POS    = 13;
	localparam int BIT_FILE_POS   = 15;
	localparam int BIT_BASE_POS   = 14;
	localparam int BIT_BASE_LSB   = 10;
	localparam int LIT_BYTE_POS   = 15;
	localparam int LIT_HASDST_POS = 14;
	localparam int LIT_LSB        = 4;
	localparam int LIT_DST_LSB    = 0;

	// Limits and cycle counts
	localparam logic [LIT_W-1:0] BYTE_LIT_MAX = 10'h0FF;
	localparam logic [REG_W-1:0] DEFAULT_WORKING_REG = 4'h0;
	localparam logic [CYC_W-1:0] CYC_1 = 2'h1;
	localparam logic [CYC_W-1:0] CYC_2 = 2'h2;
	localparam logic [CYC_W-1:0] CYC_3 = 2'h3;

	typedef enum logic [3:0] {
		CLS_NOP, CLS_W3, CLS_FILE, CLS_BIT, CLS_LIT, CLS_COND, CLS_JREL,
		CLS_IND, CLS_TABLE, CLS_RET, CLS_SKIP, CLS_DWORD, CLS_OTHER
	} iwdt_class_t;

	typedef enum logic {ST_FIRST, ST_EXT} iwdt_state_t;

	typedef struct packed {
		logic [REG_W-1:0]  baseReg;
		logic [REG_W-1:0]  srcReg;
		logic [MODE_W-1:0] srcMode;
		logic [REG_W-1:0]  dstReg;
		logic [MODE_W-1:0] dstMode;
		logic              hasDst;
		logic              dstIsW0;
		logic              isByte;
		logic [FILE_W-1:0] fileAddr;
		logic [LIT_W-1:0]  lit;
		logic [3:0]        bitPos;
		logic              bitFromBase;
		logic              targetIsFile;
	} iwdt_ops_t;

	localparam iwdt_ops_t OPS_RST = '0;

endpackage : iwdt_pkg

// ===== core/iwdt_reg_field.sv
// Extracts one working register selector and its address mode from an operand.
// Assumes the mode field sits directly above the register field.
`timescale 1ns/1ps
`default_nettype none
module iwdt_reg_field import iwdt_pkg::*; #(
	parameter int LSB = 0
) (
	// Operand bits
	input  wire logic [OPND_W-1:0] opnd,
	// Selected register and mode
	output logic      [REG_W-1:0]  regSel,
	output logic      [MODE_W-1:0] mode
);

	assign regSel = opnd[LSB +: REG_W];
	assign mode   = opnd[LSB + REG_W +: MODE_W];

endmodule : iwdt_reg_field
`default_nettype wire

// ===== core/iwdt_classify.sv
// Classifies one program word by its opcode byte.
// Assumes a purely combinational use on the core clock.
`timescale 1ns/1ps
`default_nettype none
module iwdt_classify import iwdt_pkg::*; (
	// Program word
	input  wire logic [WORD_W-1:0] word,
	// Class
	output var iwdt_class_t        cls,
	output logic                   isDword
);

	logic [OPC_W-1:0] opc;

	assign opc     = word[WORD_W-1 -: OPC_W];
	assign isDword = (cls == CLS_DWORD);

	always_comb begin
		cls = CLS_OTHER;
		if (opc == OPC_NOP)
			cls = CLS_NOP;
		else if (opc == OPC_CALL_ABS || opc == OPC_JUMP_ABS || opc == OPC_MOVE_DWORD)
			cls = CLS_DWORD;
		else if (opc == OPC_COMPUTED)
			cls = CLS_IND;
		else if (opc == OPC_RETURN || opc == OPC_INT_EXIT)
			cls = CLS_RET;
		else if (opc == OPC_JUMP_REL)
			cls = CLS_JREL;
		else if (opc == OPC_SKIP_CLR || opc == OPC_SKIP_SET)
			cls = CLS_SKIP;
		else if (opc == OPC_TBL_RD || opc == OPC_TBL_WR)
			cls = CLS_TABLE;
		else if (opc[7:4] == GRP_COND)
			cls = CLS_COND;
		else if (opc[7:4] >= GRP_W3_LO && opc[7:4] <= GRP_W3_HI)
			cls = CLS_W3;
		else if (opc[7:4] == GRP_LIT)
			cls = CLS_LIT;
		else if (opc[7:4] == GRP_BIT)
			cls = CLS_BIT;
		else if (opc[7:4] == GRP_FILE)
			cls = CLS_FILE;
	end

endmodule : iwdt_classify
`default_nettype wire

// ===== core/iwdt_decoder.sv
// Instruction word decoder with cycle count reporting.
// Assumes the fetch stage offers one word with its successor, and execution
// supplies the condition result in the same cycle.
// Notes on behaviour
// - Nearly all instructions are one 24-bit word; three take two words.
// - Single words carry an 8-bit opcode plus operand fields.
// - Double-word instructions span 48 bits; extension top byte is zero.
// - An extension word executed alone behaves as a no-operation.
// - Most single-word instructions take one cycle.
// - Taken condition or program counter change costs two cycles.
// - Jumps, indirect calls, table accesses and returns take two or three cycles.
// - Taken skip costs two cycles, three over a double-word instruction.
// - Double-word instructions, double moves included, take two cycles.
// - Register instructions decode base, source and destination with modes.
// - Memory-operand instructions decode an address and memory or register zero.
// - Bit instructions decode register or memory target plus bit position.
// - Literal arithmetic decodes base, literal and optional destination.
// - Ten-bit literal limited to 255 in byte mode, 1023 in word mode.
// - Register fields select one of sixteen working registers.
`timescale 1ns/1ps
`default_nettype none
module iwdt_decoder import iwdt_pkg::*; (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Fetch side
	input  wire logic              wordValid,
	input  wire logic [WORD_W-1:0] word,
	input  wire logic [WORD_W-1:0] nextWord,
	// Execution side
	input  wire logic              condTrue,
	// Decoded instruction
	output logic                   issueValid,
	output var iwdt_class_t        issueClass,
	output var iwdt_ops_t          issueOps,
	output logic      [CYC_W-1:0]  issueCycles,
	output logic                   litOverRange,
	// Extension word
	output logic                   needExt,
	output logic                   extValid,
	output logic      [OPND_W-1:0] extWord,
	output logic                   extError
);

	iwdt_state_t       state;
	iwdt_class_t       curClass;
	iwdt_ops_t         next_ops;
	logic              curDword;
	logic              nextDword;
	logic [OPC_W-1:0]  opc;
	logic [OPND_W-1:0] opnd;
	logic [REG_W-1:0]  srcReg;
	logic [MODE_W-1:0] srcMode;
	logic [REG_W-1:0]  dstReg;
	logic [MODE_W-1:0] dstMode;
	logic [CYC_W-1:0]  next_cycles;
	logic              next_litOver;
	logic              takeFirst;
	logic              takeExt;

	assign opc       = word[WORD_W-1 -: OPC_W];
	assign opnd      = word[OPND_W-1:0];
	assign takeFirst = wordValid && (state == ST_FIRST);
	assign takeExt   = wordValid && (state == ST_EXT);

	// Word classes of the current and following words
	iwdt_classify u_curClass (
		.word    (word),
		.cls     (curClass),
		.isDword (curDword)
	);

	iwdt_classify u_nextClass (
		.word    (nextWord),
		.cls     (),
		.isDword (nextDword)
	);

	// Source and destination register fields
	iwdt_reg_field #(.LSB(SRC_LSB)) u_srcField (
		.opnd   (opnd),
		.regSel (srcReg),
		.mode   (srcMode)
	);

	iwdt_reg_field #(.LSB(DST_LSB)) u_dstField (
		.opnd   (opnd),
		.regSel (dstReg),
		.mode   (dstMode)
	);

	// Operand decode per class
	always_comb begin
		next_ops = OPS_RST;
		case (curClass)
			CLS_W3: begin
				next_ops.baseReg = opc[REG_W-1:0];
				next_ops.srcReg  = srcReg;
				next_ops.srcMode = srcMode;
				next_ops.dstReg  = dstReg;
				next_ops.dstMode = dstMode;
				next_ops.hasDst  = 1'b1;
				next_ops.isByte  = opnd[W3_BYTE_POS];
			end
			CLS_FILE: begin
				next_ops.fileAddr = opnd[FILE_W-1:0];
				next_ops.dstIsW0  = opnd[FILE_W0_POS];
				next_ops.dstReg   = DEFAULT_WORKING_REG;
				next_ops.hasDst   = opnd[FILE_W0_POS];
				next_ops.isByte   = opnd[FILE_BYTE_POS];
			end
			CLS_BIT, CLS_SKIP: begin
				next_ops.targetIsFile = opnd[BIT_FILE_POS];
				next_ops.bitPos       = opc[3:0];
				if (opnd[BIT_FILE_POS]) begin
					next_ops.fileAddr = opnd[FILE_W-1:0];
				end else begin
					next_ops.srcReg      = srcReg;
					next_ops.srcMode     = srcMode;
					next_ops.bitFromBase = opnd[BIT_BASE_POS];
					next_ops.baseReg     = opnd[BIT_BASE_LSB +: REG_W];
					if (opnd[BIT_BASE_POS])
						next_ops.bitPos = 4'h0;
				end
			end
			CLS_LIT: begin
				next_ops.baseReg = opc[REG_W-1:0];
				next_ops.isByte  = opnd[LIT_BYTE_POS];
				next_ops.lit     = opnd[LIT_LSB +: LIT_W];
				next_ops.hasDst  = opnd[LIT_HASDST_POS];
				next_ops.dstReg  = opnd[LIT_HASDST_POS] ? opnd[LIT_DST_LSB +: REG_W] : opc[REG_W-1:0];
			end
			default: begin
			end
		endcase
	end

	// Byte-mode literal range check
	always_comb begin
		next_litOver = (curClass == CLS_LIT) && opnd[LIT_BYTE_POS]
			&& (opnd[LIT_LSB +: LIT_W] > BYTE_LIT_MAX);
	end

	// Cycle count per class
	always_comb begin
		case (curClass)
			CLS_COND:                    next_cycles = condTrue ? CYC_2 : CYC_1;
			CLS_JREL, CLS_IND, CLS_TABLE: next_cycles = CYC_2;
			CLS_RET:                     next_cycles = CYC_3;
			CLS_SKIP:                    next_cycles = !condTrue ? CYC_1 : (nextDword ? CYC_3 : CYC_2);
			CLS_DWORD:                   next_cycles = CYC_2;
			default:                     next_cycles = CYC_1;
		endcase
	end

	// Word sequencing
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ST_FIRST;
		end else if (wordValid) begin
			case (state)
				ST_FIRST: state <= curDword ? ST_EXT : ST_FIRST;
				ST_EXT:   state <= ST_FIRST;
				default:  state <= ST_FIRST;
			endcase
		end
	end

	// Issue of a first word
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			issueValid   <= 1'b0;
			issueClass   <= CLS_NOP;
			issueOps     <= OPS_RST;
			issueCycles  <= CYC_1;
			litOverRange <= 1'b0;
		end else begin
			issueValid <= takeFirst;
			if (takeFirst) begin
				issueClass   <= curClass;
				issueOps     <= next_ops;
				issueCycles  <= next_cycles;
				litOverRange <= next_litOver;
			end
		end
	end

	// Extension request to fetch
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			needExt <= 1'b0;
		else if (wordValid)
			needExt <= takeFirst && curDword;
	end

	// Extension word capture
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			extValid <= 1'b0;
			extWord  <= '0;
			extError <= 1'b0;
		end else begin
			extValid <= takeExt;
			if (takeExt) begin
				extWord  <= opnd;
				extError <= |opc;
			end
		end
	end

	AST_DWORD_EXT: assert property (@(posedge clock) disable iff (rst)
		takeFirst && curDword |=> needExt && issueValid && issueCycles == CYC_2 && issueClass == CLS_DWORD)
		else $error("double-word instruction did not request its extension");

	AST_EXT_NOT_ISSUED: assert property (@(posedge clock) disable iff (rst)
		takeExt |=> !issueValid && extValid && !needExt)
		else $error("extension word was issued as an instruction");

	AST_EXT_TOP_ZERO: assert property (@(posedge clock) disable iff (rst)
		takeExt |=> extError == ($past(opc) != 8'h00) && extWord == $past(opnd))
		else $error("extension word check wrong");

	AST_LONE_EXT_NOP: assert property (@(posedge clock) disable iff (rst)
		takeFirst && opc == OPC_NOP |=> issueClass == CLS_NOP && issueCycles == CYC_1 && !needExt)
		else $error("lone extension word not a no-operation");

	AST_SKIP_CYCLES: assert property (@(posedge clock) disable iff (rst)
		takeFirst && curClass == CLS_SKIP && condTrue |=> issueCycles == ($past(nextDword) ? CYC_3 : CYC_2))
		else $error("taken skip has wrong cycle count");

	AST_COND_CYCLES: assert property (@(posedge clock) disable iff (rst)
		takeFirst && curClass == CLS_COND |=> issueCycles == ($past(condTrue) ? CYC_2 : CYC_1))
		else $error("conditional branch cycle count wrong");

	AST_RET_CYCLES: assert property (@(posedge clock) disable iff (rst)
		takeFirst && (opc == OPC_RETURN || opc == OPC_INT_EXIT) |=> issueCycles == CYC_3)
		else $error("return cycle count wrong");

	AST_JUMP_CYCLES: assert property (@(posedge clock) disable iff (rst)
		takeFirst && (opc == OPC_JUMP_REL || opc == OPC_TBL_RD || opc == OPC_COMPUTED) |=> issueCycles == CYC_2)
		else $error("jump or table cycle count wrong");

	AST_W3_ONE: assert property (@(posedge clock) disable iff (rst)
		takeFirst && curClass == CLS_W3 |=> issueCycles == CYC_1 && issueOps.baseReg == $past(opc[3:0]))
		else $error("register instruction decode wrong");

	AST_LIT_RANGE: assert property (@(posedge clock) disable iff (rst)
		issueValid && issueClass == CLS_LIT |-> litOverRange == (issueOps.isByte && issueOps.lit > 10'h0FF))
		else $error("byte literal range flag wrong");

	AST_FILE_W0: assert property (@(posedge clock) disable iff (rst)
		issueValid && issueClass == CLS_FILE |-> issueOps.dstReg == 4'h0 && issueOps.hasDst == issueOps.dstIsW0)
		else $error("memory operand destination wrong");

	AST_SINGLE_NO_EXT: assert property (@(posedge clock) disable iff (rst)
		takeFirst && !curDword |=> issueValid && !needExt)
		else $error("single-word instruction requested an extension");

	AST_W3_FIELDS: assert property (@(posedge clock) disable iff (rst)
		takeFirst && curClass == CLS_W3 |=> issueOps.hasDst
			&& issueOps.srcReg == $past(opnd[SRC_LSB +: REG_W]) && issueOps.dstReg == $past(opnd[DST_LSB +: REG_W]))
		else $error("register operand fields wrong");

	AST_LIT_DST: assert property (@(posedge clock) disable iff (rst)
		issueValid && issueClass == CLS_LIT && !issueOps.hasDst |-> issueOps.dstReg == issueOps.baseReg)
		else $error("literal destination without field differs from base");

	AST_BIT_FROM_BASE: assert property (@(posedge clock) disable iff (rst)
		issueValid && issueClass == CLS_BIT && issueOps.bitFromBase |-> !issueOps.targetIsFile && issueOps.bitPos == 4'h0)
		else $error("bit position from base register decoded wrong");

	AST_BIT_LITERAL: assert property (@(posedge clock) disable iff (rst)
		takeFirst && curClass == CLS_BIT && !opnd[BIT_BASE_POS] |=> issueOps.bitPos == $past(opc[3:0]))
		else $error("literal bit position decoded wrong");

	AST_FILE_ADDR: assert property (@(posedge clock) disable iff (rst)
		takeFirst && curClass == CLS_FILE |=> issueOps.fileAddr == $past(opnd[FILE_W-1:0])
			&& issueOps.isByte == $past(opnd[FILE_BYTE_POS]))
		else $error("memory operand address decoded wrong");

	AST_ISSUE_ONLY_FIRST: assert property (@(posedge clock) disable iff (rst)
		!takeFirst |=> !issueValid)
		else $error("issue without a first word");

	AST_EXT_ONLY_TAKEN: assert property (@(posedge clock) disable iff (rst)
		!takeExt |=> !extValid)
		else $error("extension capture without an extension word");

	AST_DWORD_MOVE: assert property (@(posedge clock) disable iff (rst)
		takeFirst && opc == OPC_MOVE_DWORD |=> issueCycles == CYC_2 && needExt)
		else $error("double move cycle count wrong");

	AST_TABLE_WR: assert property (@(posedge clock) disable iff (rst)
		takeFirst && opc == OPC_TBL_WR |=> issueCycles == CYC_2 && issueClass == CLS_TABLE)
		else $error("table write cycle count wrong");

	AST_SKIP_NOT_TAKEN: assert property (@(posedge clock) disable iff (rst)
		takeFirst && curClass == CLS_SKIP && !condTrue |=> issueCycles == CYC_1)
		else $error("skip not performed has wrong cycle count");

	COV_DWORD_PAIR: cover property (@(posedge clock) disable iff (rst) takeFirst && curDword ##1 takeExt);
	COV_SKIP_DOUBLE: cover property (@(posedge clock) disable iff (rst)
		issueValid && issueClass == CLS_SKIP && issueCycles == CYC_3);
	COV_COND_TAKEN: cover property (@(posedge clock) disable iff (rst)
		issueValid && issueClass == CLS_COND && issueCycles == CYC_2);
	COV_LIT_OVER: cover property (@(posedge clock) disable iff (rst) litOverRange && issueValid);
	COV_EXT_ERROR: cover property (@(posedge clock) disable iff (rst) extValid && extError);

endmodule : iwdt_decoder
`default_nettype wire

// ===== tb/iwdt_fetch_model.sv
// Fetch stage and execution model that offers program words to the decoder.
// Assumes tasks are entered at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module iwdt_fetch_model import iwdt_pkg::*; (
	// Clock
	input  wire logic              clock,
	// Offered word
	output logic                   wordValid,
	output logic      [WORD_W-1:0] word,
	output logic      [WORD_W-1:0] nextWord,
	// Condition result
	output logic                   condTrue
);
	initial begin
		wordValid = 1'b0;
		word      = '0;
		nextWord  = '0;
		condTrue  = 1'b0;
	end

	// Offer one word for one rising edge
	task automatic offer(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] nw, input logic ct);
		wordValid = 1'b1;
		word      = w;
		nextWord  = nw;
		condTrue  = ct;
		@(posedge clock);
		@(negedge clock);
	endtask : offer

	// Release the word lines; they no longer show the last value
	task automatic idle();
		wordValid = 1'b0;
		word      = ~word;
		nextWord  = ~nextWord;
		condTrue  = ~condTrue;
		@(posedge clock);
		@(negedge clock);
	endtask : idle
endmodule : iwdt_fetch_model
`default_nettype wire

// ===== tb/iwdt_decoder_test.sv
// Self-checking bench for the instruction word decoder.
// Assumes the fetch model drives all decoder inputs except clock and reset at falling edges.
`timescale 1ns/1ps
`default_nettype none
module iwdt_decoder_test;
	import iwdt_pkg::*;
	logic              clock = 1'b0;
	logic              rst   = 1'b1;
	logic              wordValid;
	logic [WORD_W-1:0] word;
	logic [WORD_W-1:0] nextWord;
	logic              condTrue;
	logic              issueValid;
	iwdt_class_t       issueClass;
	iwdt_ops_t         issueOps;
	logic [CYC_W-1:0]  issueCycles;
	logic              litOverRange;
	logic              needExt;
	logic              extValid;
	logic [OPND_W-1:0] extWord;
	logic              extError;
	int                miscompares = 0;
	int                check_count = 0;

	always #5 clock = ~clock;

	iwdt_fetch_model i_fetch (.clock(clock), .wordValid(wordValid), .word(word), .nextWord(nextWord),
		.condTrue(condTrue));
	iwdt_decoder i_dut (.clock(clock), .rst(rst), .wordValid(wordValid), .word(word), .nextWord(nextWord),
		.condTrue(condTrue), .issueValid(issueValid), .issueClass(issueClass), .issueOps(issueOps),
		.issueCycles(issueCycles), .litOverRange(litOverRange), .needExt(needExt), .extValid(extValid),
		.extWord(extWord), .extError(extError));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	task automatic t_reset();
		chk(issueValid, 1'b0);
		chk(issueClass, CLS_NOP);
		chk(issueOps, OPS_RST);
		chk(issueCycles, CYC_1);
		chk({litOverRange, needExt, extValid, extError, extWord}, '0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_cycles();
		logic [7:0]       opc [15] = '{8'h00, 8'h01, 8'h05, 8'h06, 8'h37, 8'hBA, 8'hBB, 8'h30, 8'h30, 8'h45,
			8'h73, 8'hE0, 8'hA3, 8'hA6, 8'h90};
		logic             ct [15]  = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0};
		iwdt_class_t      cl [15]  = '{CLS_NOP, CLS_IND, CLS_RET, CLS_RET, CLS_JREL, CLS_TABLE, CLS_TABLE,
			CLS_COND, CLS_COND, CLS_W3, CLS_LIT, CLS_FILE, CLS_BIT, CLS_SKIP, CLS_OTHER};
		logic [CYC_W-1:0] cy [15]  = '{CYC_1, CYC_2, CYC_3, CYC_3, CYC_2, CYC_2, CYC_2, CYC_1, CYC_2, CYC_1,
			CYC_1, CYC_1, CYC_1, CYC_1, CYC_1};
		for (int i = 0; i < 15; i++) begin
			i_fetch.offer({opc[i], 16'h0000}, 24'h000000, ct[i]);
			chk(issueValid, 1'b1);
			chk(issueClass, cl[i]);
			chk(issueCycles, cy[i]);
			chk(needExt, 1'b0);
		end
		i_fetch.idle();
		chk(issueValid, 1'b0);
		$display("test cycles done");
	endtask : t_cycles

	task automatic t_skip();
		logic [7:0] nx [4] = '{8'h00, 8'h02, 8'h04, 8'h08};
		for (int i = 0; i < 4; i++) begin
			i_fetch.offer({OPC_SKIP_SET, 16'h0000}, {nx[i], 16'h0000}, 1'b1);
			chk(issueCycles, (i == 0) ? CYC_2 : CYC_3);
			i_fetch.offer({OPC_SKIP_CLR, 16'h0000}, {nx[i], 16'h0000}, 1'b0);
			chk(issueCycles, CYC_1);
		end
		$display("test skip done");
	endtask : t_skip

	task automatic t_dword();
		logic [7:0] dw [3] = '{OPC_CALL_ABS, OPC_JUMP_ABS, OPC_MOVE_DWORD};
		for (int i = 0; i < 3; i++) begin
			i_fetch.offer({dw[i], 16'h1234}, 24'h000000, 1'b0);
			chk({issueValid, needExt}, 2'b11);
			chk(issueClass, CLS_DWORD);
			chk(issueCycles, CYC_2);
			if (i == 1) begin
				i_fetch.idle();
				chk({issueValid, needExt}, 2'b01);
			end
			i_fetch.offer({8'h00, 16'hBEE0 + 16'(i)}, 24'h000000, 1'b1);
			chk({issueValid, extValid, needExt, extError}, 4'b0100);
			chk(extWord, 16'hBEE0 + 16'(i));
		end
		i_fetch.offer({OPC_JUMP_ABS, 16'h0000}, 24'h000000, 1'b0);
		i_fetch.offer(24'h5A0F0F, 24'h000000, 1'b0);
		chk({issueValid, extValid, extError}, 3'b011);
		i_fetch.offer(24'h00ABCD, 24'h000000, 1'b0);
		chk({issueValid, needExt}, 2'b10);
		chk(issueClass, CLS_NOP);
		chk(issueCycles, CYC_1);
		$display("test double word done");
	endtask : t_dword

	task automatic t_fields();
		i_fetch.offer(24'h45555C, 24'h000000, 1'b0);
		chk({issueOps.baseReg, issueOps.srcReg, issueOps.dstReg}, 12'h5CA);
		chk({issueOps.srcMode, issueOps.dstMode, issueOps.isByte}, 7'b101_010_1);
		i_fetch.offer(24'hE03ABC, 24'h000000, 1'b0);
		chk(issueOps.fileAddr, 13'h1ABC);
		chk({issueOps.dstIsW0, issueOps.isByte, issueOps.dstReg}, {2'b10, DEFAULT_WORKING_REG});
		i_fetch.offer(24'h43078F, 24'h000000, 1'b0);
		chk({issueOps.srcReg, issueOps.dstReg}, 8'hFF);
		i_fetch.offer(24'h739FF0, 24'h000000, 1'b0);
		chk({litOverRange, issueOps.isByte, issueOps.hasDst}, 3'b110);
		chk({issueOps.lit, issueOps.baseReg, issueOps.dstReg}, {10'h1FF, 8'h33});
		i_fetch.offer(24'h73CFF5, 24'h000000, 1'b0);
		chk({litOverRange, issueOps.hasDst, issueOps.dstReg}, 6'b0_1_0101);
		i_fetch.offer(24'h735FF0, 24'h000000, 1'b0);
		chk({litOverRange, issueOps.lit}, {1'b0, 10'h1FF});
		i_fetch.offer(24'hA38123, 24'h000000, 1'b0);
		chk({issueOps.targetIsFile, issueOps.bitPos, issueOps.fileAddr}, {5'h13, 13'h0123});
		i_fetch.offer(24'hA36400, 24'h000000, 1'b0);
		chk({issueOps.targetIsFile, issueOps.bitFromBase, issueOps.baseReg}, 6'b01_1001);
		chk(issueOps.bitPos, 4'h0);
		$display("test fields done");
	endtask : t_fields

	initial begin
		#200us;
		miscompares++;
		close_out();
	end

	initial begin
		repeat (5) @(posedge clock);
		@(negedge clock);
		t_reset();
		rst = 1'b0;
		t_cycles();
		t_skip();
		t_dword();
		t_fields();
		i_fetch.idle();
		close_out();
	end
endmodule : iwdt_decoder_test
`default_nettype wire
